// File: hw/oscd_defines.svh
// Constants of the oscillation stop detector and CPU clock control.
// Assumes a 100 MHz system clock that also stands for the on-chip oscillator.
`ifndef OSCD_DEFINES_SVH
`define OSCD_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define OSCD_ADDR_CPU_MODE    8'h00
`define OSCD_ADDR_MISC_CTRL   8'h04
`define OSCD_ADDR_ONCHIP_DIV  8'h08

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OSCD_CPU_MODE_REGISTER_PROC_LO     0
`define OSCD_CPU_MODE_REGISTER_INT_STOP    3
`define OSCD_CPU_MODE_REGISTER_MAIN_STOP   4
`define OSCD_CPU_MODE_REGISTER_OSC_MODE    5
`define OSCD_CPU_MODE_REGISTER_DIV_LO      6
`define OSCD_MISC_DET_EN      0
`define OSCD_MISC_RST_EN      1
`define OSCD_MISC_FLAG        2

// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define OSCD_CPU_MODE_REGISTER_RESET       8'h80
`define OSCD_DIV_ONCHIP_SEL   2'h2
`define OSCD_ODIV_RESET       2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OSCD_SYS_CLK_MHZ      100
`define OSCD_STOP_TIME_NS     10000
`define OSCD_STOP_CYCLES      ((`OSCD_STOP_TIME_NS * `OSCD_SYS_CLK_MHZ) / 1000)
`define OSCD_INT_RST_CYCLES   16

`endif

// File: hw/oscd_pkg.sv
// Types of the oscillation stop detector and CPU clock control.
// Assumes oscd_defines.svh is on the include path.
package oscd_pkg;

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] div_sel;
    logic       osc_mode;
    logic       main_stop;
    logic       int_stop;
    logic       rsvd;
    logic [1:0] proc_mode;
  } oscd_cpu_mode_register_type;

  typedef struct packed {
    logic flag;
    logic rst_en;
    logic det_en;
  } oscd_misc_type;

  // ---------------------------------------------------------------
  // Internal reset sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OSCD_RUN  = 2'b01,
    OSCD_IRST = 2'b10
  } oscd_rst_state_type;

endpackage

// File: hw/oscd_stop_detector.sv
// Main oscillator watchdog: synchronises the main oscillator pin and
// reports its rising edges and a loss of oscillation.
// Assumes the main oscillator runs below a quarter of the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "oscd_defines.svh"

module oscd_stop_detector
  import oscd_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic main_osc_i,
  input  wire logic enable_i,
  output logic      main_tick_o,
  output logic      stop_o
);

  localparam int unsigned STOP_CYCLES = `OSCD_STOP_CYCLES;

  logic        sync1_ff;
  logic        sync2_ff;
  logic        last_ff;
  logic [15:0] idle_cnt_ff;
  logic        stop_ff;

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    sync1_ff <= main_osc_i;
    sync2_ff <= sync1_ff;
    last_ff  <= sync2_ff;
  end

  assign main_tick_o = sync2_ff & ~last_ff;
  assign stop_o      = stop_ff;

  // ---------------------------------------------------------------
  // Idle counter
  // ---------------------------------------------------------------
  // Counts system clock cycles without a main edge; restarts after a hit
  // so a dead oscillator is reported again once per timeout.
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !enable_i || main_tick_o) // see RL2
    begin
      idle_cnt_ff <= 16'h0000;
      stop_ff     <= 1'b0;
    end
    else if (idle_cnt_ff == 16'(STOP_CYCLES - 1)) // see RL18
    begin
      idle_cnt_ff <= 16'h0000;
      stop_ff     <= 1'b1;
    end
    else
    begin
      idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      stop_ff     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: hw/oscd_clock_control.sv
// Oscillation stop detection with internal reset, CPU clock source and
// division control, reached over APB.
// Assumes SYS_CLK_I stands for the on-chip oscillator; RESETN_I is the
// external reset, already synchronous to SYS_CLK_I.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "oscd_defines.svh"

// Operation
// RL1: Software keeps the on-chip oscillator running while stop detection is used.
// RL2: With detection enabled, the main oscillator is watched against the on-chip clock.
// RL3: A detected main oscillator stop sets the status flag.
// RL4: Stop raises internal reset only when stop-reset enable is set.
// RL5: The status flag survives the internal reset caused by a stop.
// RL6: External reset clears the status flag.
// RL7: Writing 0 to detection enable clears the status flag.
// RL8: Detection enable is kept through the stop-caused internal reset.
// RL9: Software avoids the halt oscillator instruction while detection is on.
// RL10: Software never runs main clock with detection on but stop reset off.
// RL11: Main clock divides by 2, 8, or 1; 1 only with ceramic.
// RL12: On-chip clock divides by 1, 2, 8 or 128.
// RL13: On-chip divide by 8 after reset and after returning from main clock.
// RL14: Software switches to main clock only after it has stabilised.
// RL15: Oscillation mode and processor mode bits take one write after reset.
// RL16: Software never stops the oscillator selected as operating clock.
// RL17: Any write to the cpu mode register locks the write-once bits.
// RL18: Stop declared when no main edge arrives within a fixed cycle count.
module oscd_clock_control
  import oscd_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        MAIN_OSC_I,
  output logic             CPU_CLK_EN_O,
  output logic             INT_RESET_O,
  output logic      [1:0]  PROC_MODE_O
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  oscd_cpu_mode_register_type      cpu_mode_register_ff;
  oscd_misc_type      misc_ff;
  oscd_rst_state_type rst_state_ff;
  logic [1:0]         odiv_ff;
  logic               lock_ff;
  logic               src_main_ff;
  logic [4:0]         irst_cnt_ff;
  logic [6:0]         div_cnt_ff;
  logic               cpu_en_ff;
  logic               ready_ff;
  logic               slverr_ff;
  logic [31:0]        rdata_ff;
  logic               main_tick;
  logic               stop_raw;
  logic               stop_evt;
  logic               int_rst;
  logic               regs_rst;
  logic               src_main;
  logic               wr_acc;
  logic               wr_cpu_mode_register;
  logic               wr_misc;
  logic               wr_odiv;
  logic               tick;
  logic [6:0]         limit;
  logic [31:0]        nxt_rdata;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `OSCD_ADDR_CPU_MODE) || (a == `OSCD_ADDR_MISC_CTRL) ||
               (a == `OSCD_ADDR_ONCHIP_DIV);
  endfunction

  // Terminal count of the CPU divider for the selected source and ratio
  function automatic logic [6:0] div_limit(input logic       on_main,
                                           input logic [1:0] dsel,
                                           input logic       rc_mode,
                                           input logic [1:0] osel);
    logic [6:0] r;
    r = 7'h00;
    if (on_main)
    begin
      // Double speed is refused under RC and falls back to high speed
      unique case (dsel)
        2'h0:    r = 7'h01;
        2'h1:    r = 7'h07;
        default: r = rc_mode ? 7'h01 : 7'h00; // see RL11
      endcase
    end
    else
    begin
      unique case (osel) // see RL12
        2'h0: r = 7'h00;
        2'h1: r = 7'h01;
        2'h2: r = 7'h07;
        2'h3: r = 7'h7f;
      endcase
    end
    div_limit = r;
  endfunction

  // ---------------------------------------------------------------
  // Stop detector
  // ---------------------------------------------------------------
  // The watch needs the on-chip clock, so it idles while that is stopped
  oscd_stop_detector u_det (
    .sys_clk_i  (SYS_CLK_I),
    .resetn_i   (RESETN_I),
    .main_osc_i (MAIN_OSC_I),
    .enable_i   (misc_ff.det_en & ~cpu_mode_register_ff.int_stop), // see RL1
    .main_tick_o(main_tick),
    .stop_o     (stop_raw)
  );

  assign stop_evt = stop_raw & misc_ff.det_en; // see RL2
  assign int_rst  = (rst_state_ff == OSCD_IRST);
  assign regs_rst = ~RESETN_I | int_rst;
  assign src_main = (cpu_mode_register_ff.div_sel != `OSCD_DIV_ONCHIP_SEL);

  // ---------------------------------------------------------------
  // Internal reset sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      rst_state_ff <= OSCD_RUN;
      irst_cnt_ff  <= 5'h00;
    end
    else
    begin
      unique case (rst_state_ff)
        OSCD_RUN:
        begin
          if (stop_evt && misc_ff.rst_en) // see RL4
          begin
            rst_state_ff <= OSCD_IRST;
            irst_cnt_ff  <= 5'(`OSCD_INT_RST_CYCLES - 1);
          end
        end
        OSCD_IRST:
        begin
          if (irst_cnt_ff == 5'h00)
          begin
            rst_state_ff <= OSCD_RUN;
          end
          else
          begin
            irst_cnt_ff <= irst_cnt_ff - 5'h01;
          end
        end
        default:
        begin
          rst_state_ff <= OSCD_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait state so that every answer leaves a flip-flop
  assign wr_acc  = PSEL_I & PENABLE_I & PWRITE_I & ready_ff & ~slverr_ff & ~int_rst;
  assign wr_cpu_mode_register = wr_acc & (PADDR_I == `OSCD_ADDR_CPU_MODE);
  assign wr_misc = wr_acc & (PADDR_I == `OSCD_ADDR_MISC_CTRL);
  assign wr_odiv = wr_acc & (PADDR_I == `OSCD_ADDR_ONCHIP_DIV);

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (PADDR_I == `OSCD_ADDR_CPU_MODE)
    begin
      nxt_rdata[7:0] = cpu_mode_register_ff;
    end
    else if (PADDR_I == `OSCD_ADDR_MISC_CTRL)
    begin
      nxt_rdata[2:0] = misc_ff;
    end
    else if (PADDR_I == `OSCD_ADDR_ONCHIP_DIV)
    begin
      nxt_rdata[1:0] = odiv_ff;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      ready_ff  <= 1'b0;
      slverr_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      ready_ff  <= PSEL_I & PENABLE_I & ~ready_ff;
      slverr_ff <= PSEL_I & PENABLE_I & ~ready_ff & ~addr_hit(PADDR_I);
      if (PSEL_I && PENABLE_I && !ready_ff && !PWRITE_I)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // CPU mode register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (regs_rst)
    begin
      cpu_mode_register_ff <= `OSCD_CPU_MODE_REGISTER_RESET;
      lock_ff <= 1'b0;
    end
    else if (wr_cpu_mode_register)
    begin
      cpu_mode_register_ff.div_sel   <= PWDATA_I[`OSCD_CPU_MODE_REGISTER_DIV_LO +: 2];
      cpu_mode_register_ff.main_stop <= PWDATA_I[`OSCD_CPU_MODE_REGISTER_MAIN_STOP];
      cpu_mode_register_ff.int_stop  <= PWDATA_I[`OSCD_CPU_MODE_REGISTER_INT_STOP];
      lock_ff           <= 1'b1; // see RL17
      if (!lock_ff) // see RL15
      begin
        cpu_mode_register_ff.osc_mode  <= PWDATA_I[`OSCD_CPU_MODE_REGISTER_OSC_MODE];
        cpu_mode_register_ff.proc_mode <= PWDATA_I[`OSCD_CPU_MODE_REGISTER_PROC_LO +: 2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Misc control register
  // ---------------------------------------------------------------
  // Only the external reset touches it, so the cause stays readable
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I) // see RL6
    begin
      misc_ff <= 3'h0;
    end
    else
    begin
      if (wr_misc) // see RL8
      begin
        misc_ff.det_en <= PWDATA_I[`OSCD_MISC_DET_EN];
        misc_ff.rst_en <= PWDATA_I[`OSCD_MISC_RST_EN];
      end
      if (stop_evt) // see RL3
      begin
        misc_ff.flag <= 1'b1; // see RL5
      end
      else if (wr_misc && !PWDATA_I[`OSCD_MISC_DET_EN])
      begin
        misc_ff.flag <= 1'b0; // see RL7
      end
    end
  end

  // ---------------------------------------------------------------
  // On-chip division and source tracking
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (regs_rst)
    begin
      odiv_ff     <= `OSCD_ODIV_RESET; // see RL13
      src_main_ff <= 1'b0;
    end
    else
    begin
      src_main_ff <= src_main;
      if (src_main_ff && !src_main)
      begin
        odiv_ff <= `OSCD_ODIV_RESET; // see RL13
      end
      else if (wr_odiv)
      begin
        odiv_ff <= PWDATA_I[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // CPU clock divider
  // ---------------------------------------------------------------
  // A stopped source gives no ticks, so the CPU clock halts with it
  assign tick  = src_main ? (main_tick & ~cpu_mode_register_ff.main_stop) : ~cpu_mode_register_ff.int_stop;
  assign limit = div_limit(src_main, cpu_mode_register_ff.div_sel, cpu_mode_register_ff.osc_mode, odiv_ff);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (regs_rst)
    begin
      div_cnt_ff <= 7'h00;
      cpu_en_ff  <= 1'b0;
    end
    else if (tick && div_cnt_ff >= limit)
    begin
      div_cnt_ff <= 7'h00;
      cpu_en_ff  <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= tick ? div_cnt_ff + 7'h01 : div_cnt_ff;
      cpu_en_ff  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PRDATA_O     = rdata_ff;
  assign PREADY_O     = ready_ff;
  assign PSLVERR_O    = slverr_ff;
  assign CPU_CLK_EN_O = cpu_en_ff;
  assign INT_RESET_O  = int_rst;
  assign PROC_MODE_O  = cpu_mode_register_ff.proc_mode;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  a_flag_on_stop: assert property (stop_evt |=> misc_ff.flag) // see RL3
    else $error("stop event did not set the flag");
  a_irst_on_stop: assert property (stop_evt && misc_ff.rst_en && !int_rst |=> INT_RESET_O [*8]) // see RL4
    else $error("internal reset missing after stop");
  a_no_irst_off: assert property (stop_evt && !misc_ff.rst_en && !int_rst |=> !INT_RESET_O) // see RL4
    else $error("internal reset without stop reset enable");
  a_flag_holds_irst: assert property (int_rst && misc_ff.flag |=> misc_ff.flag) // see RL5
    else $error("flag lost in internal reset");
  a_flag_ext_clear: assert property ($rose(RESETN_I) |-> !misc_ff.flag) // see RL6
    else $error("flag not cleared by external reset");
  a_flag_en_clear: assert property (wr_misc && !PWDATA_I[0] && !stop_evt |=> !misc_ff.flag) // see RL7
    else $error("flag not cleared by disabling detection");
  a_enable_kept: assert property (int_rst |=> $stable(misc_ff.det_en)) // see RL8
    else $error("detection enable changed in internal reset");
  a_div8_on_return: assert property ($fell(src_main) && !int_rst |=> odiv_ff == 2'h2) // see RL13
    else $error("on-chip divide by 8 not restored");
  a_write_once: assert property (lock_ff && wr_cpu_mode_register |=> $stable(cpu_mode_register_ff.proc_mode) && $stable(cpu_mode_register_ff.osc_mode)) // see RL15
    else $error("locked mode bits changed");
  a_write_locks: assert property (wr_cpu_mode_register |=> lock_ff || int_rst) // see RL17
    else $error("write did not lock mode bits");

  c_stop_reset: cover property (stop_evt && misc_ff.rst_en ##1 INT_RESET_O);
  c_stop_flag_only: cover property (stop_evt && !misc_ff.rst_en);
  c_main_source_tick: cover property (src_main && CPU_CLK_EN_O);
  c_locked_write: cover property (lock_ff && wr_cpu_mode_register);

endmodule
`default_nettype wire

// File: tb/oscd_clock_control_tb.sv
// Self-checking bench for the oscillation stop detector and CPU clock control.
// Assumes the design files and oscd_defines.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "oscd_defines.svh"

module oscd_clock_control_tb;
  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        main_osc = 1'b0;
  logic        clk_en;
  logic        int_rst;
  logic [1:0]  proc_mode;
  logic [31:0] rdata;
  logic        rerr;
  logic        osc_run;
  logic [1:0]  osc_cnt = 2'h0;
  logic [1:0]  pm;
  int          n_mismatch;
  int          compares;
  int          seed;
  int          n;
  int          irst_n = 0;
  int          irst_base;
  int          dv[4] = '{1, 2, 8, 128};
  int          msel[3] = '{0, 1, 3};
  int          medg[3] = '{2, 8, 1};

  oscd_clock_control dut_u (
    .SYS_CLK_I    (sys_clk),
    .RESETN_I     (resetn),
    .PSEL_I       (psel),
    .PENABLE_I    (penable),
    .PWRITE_I     (pwrite),
    .PADDR_I      (paddr),
    .PWDATA_I     (pwdata),
    .PRDATA_O     (prdata),
    .PREADY_O     (pready),
    .PSLVERR_O    (pslverr),
    .MAIN_OSC_I   (main_osc),
    .CPU_CLK_EN_O (clk_en),
    .INT_RESET_O  (int_rst),
    .PROC_MODE_O  (proc_mode)
  );

  // ---------------------------------------------------------------
  // Clocks and monitors
  // ---------------------------------------------------------------
  // On-chip reference never stops in this bench
  always #5 sys_clk = ~sys_clk;

  // Main oscillator at an eighth of the system clock
  always @(posedge sys_clk)
  begin
    if (osc_run)
    begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_cnt == 2'h3)
        main_osc <= ~main_osc;
    end
  end

  always @(posedge sys_clk)
  begin
    if (int_rst === 1'b1)
      irst_n++;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is sampled high, then releases it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_mismatch++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic cnt(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk);
      if (clk_en === 1'b1)
        c++;
    end
  endtask

  task automatic test_done;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Generous span: the sequence needs well under 10k cycles
  initial
  begin
    #500000;
    n_mismatch++;
    test_done;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; osc_run = 0;
    n_mismatch = 0; compares = 0; seed = 85050; irst_base = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`OSCD_ADDR_CPU_MODE, 32'h80);
    rd(`OSCD_ADDR_MISC_CTRL, 32'h0);
    rd(`OSCD_ADDR_ONCHIP_DIV, 32'h2);
    rd(8'h0c, 32'h0);
    chk(rerr, 1'b1);
    n = $random(seed);
    pm = n[1:0];
    apb(1'b1, `OSCD_ADDR_CPU_MODE, 32'h80 | pm);
    apb(1'b1, `OSCD_ADDR_CPU_MODE, 32'ha0 | (~pm & 2'h3));
    rd(`OSCD_ADDR_CPU_MODE, 32'h80 | pm);
    chk(proc_mode, pm);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `OSCD_ADDR_ONCHIP_DIV, i);
      repeat (8) @(posedge sys_clk);
      cnt(256, n);
      chk(n, 256 / dv[i]);
    end
    // Let the main oscillator settle before selecting it
    osc_run <= 1'b1;
    repeat (64) @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `OSCD_ADDR_CPU_MODE, msel[i] << 6);
      repeat (32) @(posedge sys_clk);
      cnt(256, n);
      // Main edges drift against the window, so one pulse either way is fine
      if (n - 32 / medg[i] == 1 || 32 / medg[i] - n == 1)
        n = 32 / medg[i];
      chk(n, 32 / medg[i]);
    end
    apb(1'b1, `OSCD_ADDR_ONCHIP_DIV, 32'h0);
    apb(1'b1, `OSCD_ADDR_CPU_MODE, 32'h80);
    rd(`OSCD_ADDR_ONCHIP_DIV, 32'h2);
    // Detection without stop reset only while on the on-chip clock
    // On-chip clock never stopped and no halt used while detection is on
    irst_base = irst_n;
    apb(1'b1, `OSCD_ADDR_MISC_CTRL, 32'h1);
    repeat (1200) @(posedge sys_clk);
    rd(`OSCD_ADDR_MISC_CTRL, 32'h1);
    osc_run <= 1'b0;
    repeat (`OSCD_STOP_CYCLES + 200) @(posedge sys_clk);
    rd(`OSCD_ADDR_MISC_CTRL, 32'h5);
    chk(irst_n - irst_base, 0);
    apb(1'b1, `OSCD_ADDR_MISC_CTRL, 32'h0);
    rd(`OSCD_ADDR_MISC_CTRL, 32'h0);
    apb(1'b1, `OSCD_ADDR_MISC_CTRL, 32'h3);
    n = 0;
    while (int_rst !== 1'b1 && n < 2000)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (int_rst === 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, `OSCD_INT_RST_CYCLES);
    osc_run <= 1'b1;
    rd(`OSCD_ADDR_MISC_CTRL, 32'h7);
    rd(`OSCD_ADDR_CPU_MODE, 32'h80);
    chk(proc_mode, 2'h0);
    apb(1'b1, `OSCD_ADDR_CPU_MODE, 32'h81);
    rd(`OSCD_ADDR_CPU_MODE, 32'h81);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`OSCD_ADDR_MISC_CTRL, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
